// *** fcs_top.sv ***
// Flash command and status register block with an APB slave.
// Assumes a 125 MHz pclk, protection decision and stop request from outside.
//
// Functional notes
// R1 - Buffer-empty flag bit 7 clears on write of 1; 0 leaves it.
// R2 - Writing 0 to buffer-empty mid-sequence aborts and sets access error.
// R3 - Writing 0 to buffer-empty outside a sequence sets no error.
// R4 - Buffer-empty reads 1 when a command fits, 0 when full.
// R5 - Complete flag bit 6 clears with buffer-empty, sets when all done.
// R6 - Complete stays clear when a burst follows a finished program.
// R7 - Writes to complete ignored; reads 0 busy, 1 done.
// R8 - Protection flag bit 5 sets on protected target; write 1 clears.
// R9 - Protection flag set blocks new sequences and launches.
// R10 - Access error bit 4 sets on sequence fault, bad code, or stop.
// R11 - Access error clears on write of 1; 0 ignored.
// R12 - Access error set blocks new sequences and launches.
// R13 - Blank flag bit 2 gives erase-verify result at completion.
// R14 - Blank clears on a valid launch; software writes ignored.
// R15 - Status bits 3,1,0 read zero; blank is read-only.
// R16 - Command code bits 6..0 writable in sequence; bit 7 reads 0.
// R17 - Codes 0x05 verify, 0x20 program, 0x25 burst accepted.
// R18 - Codes 0x40 sector erase, 0x41 mass erase accepted.
// R19 - Any other code sets access error.
// R20 - Operations timed by a divided-down timing clock.
// R21 - Without a divider write since reset, a launch errors, no run.
// R22 - Software writes address, code, then 1 to buffer-empty.
// R23 - Any change of protected data sets the protection flag.
// R24 - Reset: buffer-empty and complete read 1, others 0.
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/10ps
`include "fcs_defines.svh"
module fcs_top #(
  parameter logic [7:0] OP_TICKS = `FCS_OP_TICKS
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Array side status
  input wire logic addr_protected,
  input wire logic array_blank,
  input wire logic cpu_stop,
  // Engine state
  output logic flash_busy,
  output logic flash_timing_clock
);
  fcs_pkg::fcs_flags_t flags;
  fcs_pkg::fcs_seq_t seq;
  logic [6:0] flash_command;
  logic [31:0] seq_addr;
  logic [`FCS_DIV_W-1:0] clock_divider_setting;
  logic prescale8;
  logic div_loaded;
  logic wr;
  logic rd;
  logic wr_status;
  logic wr_cmd;
  logic wr_array;
  logic blocked;
  logic launch_req;
  logic launch;
  logic abort;
  logic eng_ready;
  logic eng_busy;
  logic eng_done;
  logic eng_verify;
  logic set_accerr;
  logic set_pviol;
  logic code_ok;
  logic seq_fault;
  fcs_pkg::fcs_cmd_t cmd;

  // Command code legality, shared by write check and sequence tracker
  function automatic logic fcs_code_valid(input logic [6:0] c);
    case (c)
      `FCS_CMD_VERIFY, `FCS_CMD_PROG, `FCS_CMD_BURST: fcs_code_valid = 1'b1; // R17
      `FCS_CMD_SECTOR, `FCS_CMD_MASS: fcs_code_valid = 1'b1; // R18
      default: fcs_code_valid = 1'b0;
    endcase
  endfunction

  // Zero-wait APB: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  assign wr_status = wr && (paddr == `FCS_OFF_STATUS);
  assign wr_cmd = wr && (paddr == `FCS_OFF_COMMAND);
  assign wr_array = wr && (paddr == `FCS_OFF_ARRAY);
  assign blocked = flags.pviol || flags.accerr; // R9 R12
  assign code_ok = fcs_code_valid(pwdata[6:0]);
  // Out-of-order writes inside a sequence; reads stay allowed
  assign seq_fault = ((seq != fcs_pkg::FCS_SEQ_IDLE) && wr_array) || ((seq == fcs_pkg::FCS_SEQ_CMD) && wr_cmd) ||
                     ((seq == fcs_pkg::FCS_SEQ_ADDR) && wr_status && pwdata[`FCS_BIT_CBEF]);

  // Launch and abort decode from the status write
  assign launch_req = wr_status && pwdata[`FCS_BIT_CBEF] && (seq == fcs_pkg::FCS_SEQ_CMD);
  assign launch = launch_req && !blocked && div_loaded && eng_ready; // R21
  assign abort = wr_status && !pwdata[`FCS_BIT_CBEF] && (seq != fcs_pkg::FCS_SEQ_IDLE); // R2 R3
  assign cmd = '{code: flash_command, addr: seq_addr};
  assign flash_busy = eng_busy;

  // Error sources gathered for the flag process
  always_comb begin
    set_accerr = 1'b0;
    if (abort) begin
      set_accerr = 1'b1; // R2
    end
    if (wr_cmd && (seq == fcs_pkg::FCS_SEQ_ADDR) && !code_ok) begin
      set_accerr = 1'b1; // R19
    end
    if (launch_req && !div_loaded) begin
      set_accerr = 1'b1; // R21
    end
    if (seq_fault) begin
      set_accerr = 1'b1; // R10
    end
    if (wr_cmd && (seq == fcs_pkg::FCS_SEQ_IDLE)) begin
      set_accerr = 1'b1; // R10
    end
    if (cpu_stop && !flags.ccf) begin
      set_accerr = 1'b1; // R10
    end
  end
  // Protected target seen at the address step
  assign set_pviol = wr_array && addr_protected && (seq == fcs_pkg::FCS_SEQ_IDLE) && !blocked; // R8 R23

  // Command write sequence tracker
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq <= fcs_pkg::FCS_SEQ_IDLE;
      seq_addr <= 32'h0000_0000;
    end else begin
      case (seq)
        fcs_pkg::FCS_SEQ_IDLE: begin
          // Ready slot needed, and no errors standing
          if (wr_array && !blocked && !addr_protected && flags.cbef) begin // R9 R12
            seq <= fcs_pkg::FCS_SEQ_ADDR;
            seq_addr <= pwdata;
          end
        end
        fcs_pkg::FCS_SEQ_ADDR: begin
          if (abort || (wr_cmd && !code_ok) || seq_fault) begin
            seq <= fcs_pkg::FCS_SEQ_IDLE;
          end else if (wr_cmd) begin
            seq <= fcs_pkg::FCS_SEQ_CMD;
          end
        end
        fcs_pkg::FCS_SEQ_CMD: begin
          if (abort || launch_req || wr_cmd || wr_array) begin
            seq <= fcs_pkg::FCS_SEQ_IDLE;
          end
        end
        default: seq <= fcs_pkg::FCS_SEQ_IDLE;
      endcase
    end
  end

  // Command code register, bit 7 not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_command <= `FCS_CMD_RESET;
    end else if (wr_cmd && (seq == fcs_pkg::FCS_SEQ_ADDR)) begin
      flash_command <= pwdata[6:0]; // R16
    end
  end

  // Divider setting and its written-since-reset mark
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_divider_setting <= `FCS_DIV_RESET;
      prescale8 <= 1'b0;
      div_loaded <= 1'b0;
    end else if (wr && (paddr == `FCS_OFF_DIVIDER)) begin
      clock_divider_setting <= pwdata[`FCS_DIV_W-1:0];
      prescale8 <= pwdata[`FCS_DIV_W];
      div_loaded <= 1'b1; // R21
    end
  end

  // Buffer-empty mirrors engine room; cleared by a launch only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags.cbef <= 1'b1; // R24
    end else if (launch) begin
      flags.cbef <= 1'b0; // R1
    end else begin
      flags.cbef <= eng_ready; // R4
    end
  end

  // Complete flag: hardware only, software writes ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags.ccf <= 1'b1; // R24
    end else if (launch) begin
      flags.ccf <= 1'b0; // R5
    end else if (eng_done) begin
      flags.ccf <= 1'b1; // R5 R6 R7
    end
  end

  // Blank result: cleared on a valid launch, set at verify end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags.blank <= 1'b0;
    end else if (eng_verify) begin
      flags.blank <= 1'b1; // R13
    end else if (launch) begin
      flags.blank <= 1'b0; // R14
    end
  end

  // Sticky error flags; a new event beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags.accerr <= 1'b0;
      flags.pviol <= 1'b0;
    end else begin
      if (set_accerr) begin
        flags.accerr <= 1'b1; // R10
      end else if (wr_status && pwdata[`FCS_BIT_ACCERR]) begin
        flags.accerr <= 1'b0; // R11
      end
      if (set_pviol) begin
        flags.pviol <= 1'b1; // R8
      end else if (wr_status && pwdata[`FCS_BIT_PVIOL]) begin
        flags.pviol <= 1'b0; // R8
      end
    end
  end

  // Read mux; unmapped reads return zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd && !penable) begin
      case (paddr)
        `FCS_OFF_STATUS: prdata <= {24'h00_0000, flags.cbef, flags.ccf, flags.pviol, flags.accerr,
                                    1'b0, flags.blank, 2'b00}; // R15
        `FCS_OFF_COMMAND: prdata <= {25'h000_0000, flash_command}; // R16
        `FCS_OFF_DIVIDER: prdata <= {24'h00_0000, prescale8, clock_divider_setting};
        `FCS_OFF_CTRL: prdata <= {30'h0000_0000, div_loaded, eng_busy};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Timing clock enable from the bus clock
  fcs_clkdiv #(
    .DIV_W(`FCS_DIV_W)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .div(clock_divider_setting),
    .prescale8(prescale8),
    .tick(flash_timing_clock) // R20
  );

  // Operation engine with two-stage store
  fcs_engine #(
    .OP_TICKS(OP_TICKS)
  ) u_eng (
    .pclk(pclk),
    .presetn(presetn),
    .launch(launch),
    .cmd(cmd),
    .ready(eng_ready),
    .tick(flash_timing_clock),
    .array_blank(array_blank),
    .busy(eng_busy),
    .done(eng_done),
    .verify_done(eng_verify)
  );

  // Checks
  sequence s_launch;
    launch;
  endsequence
  property p_launch_clears;
    @(posedge pclk) disable iff (!presetn) s_launch |=> !flags.cbef && !flags.ccf;
  endproperty
  a_launch_clears: assert property (p_launch_clears) else $error("launch did not clear flags"); // R5
  property p_abort_err;
    @(posedge pclk) disable iff (!presetn) abort |=> flags.accerr;
  endproperty
  a_abort_err: assert property (p_abort_err) else $error("abort did not set access error"); // R2
  property p_idle_zero;
    @(posedge pclk) disable iff (!presetn)
      (wr_status && !pwdata[7] && seq == fcs_pkg::FCS_SEQ_IDLE && !flags.accerr && !cpu_stop) |=> !flags.accerr;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("idle zero write set error"); // R3
  property p_blocked;
    @(posedge pclk) disable iff (!presetn) (blocked && !eng_busy) |=> !eng_busy;
  endproperty
  a_blocked: assert property (p_blocked) else $error("launch while error set"); // R9 R12
  property p_bad_code;
    @(posedge pclk) disable iff (!presetn) (wr_cmd && seq == fcs_pkg::FCS_SEQ_ADDR && !code_ok) |=> flags.accerr;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("bad code not flagged"); // R19
  property p_nodiv;
    @(posedge pclk) disable iff (!presetn) (!div_loaded && !eng_busy) |=> !eng_busy;
  endproperty
  a_nodiv: assert property (p_nodiv) else $error("launch without divider"); // R21
  property p_pviol_clear;
    @(posedge pclk) disable iff (!presetn) (wr_status && pwdata[5] && !set_pviol) |=> !flags.pviol;
  endproperty
  a_pviol_clear: assert property (p_pviol_clear) else $error("protection flag not cleared"); // R8
  property p_ccf_busy;
    @(posedge pclk) disable iff (!presetn) (flags.ccf && !$past(launch)) |-> !eng_busy || $past(eng_done);
  endproperty
  a_ccf_busy: assert property (p_ccf_busy) else $error("complete while busy"); // R7
  // Flag and store checks
  property p_blank_set;
    @(posedge pclk) disable iff (!presetn) eng_verify |=> flags.blank;
  endproperty
  a_blank_set: assert property (p_blank_set) else $error("blank not set after verify"); // R13
  property p_blank_clear;
    @(posedge pclk) disable iff (!presetn) (s_launch and !eng_verify) |=> !flags.blank;
  endproperty
  a_blank_clear: assert property (p_blank_clear) else $error("blank not cleared on launch"); // R14
  property p_seq_fault;
    @(posedge pclk) disable iff (!presetn) seq_fault |=> flags.accerr;
  endproperty
  a_seq_fault: assert property (p_seq_fault) else $error("sequence fault not flagged"); // R10
  property p_ccf_rise;
    @(posedge pclk) disable iff (!presetn) $rose(flags.ccf) |-> $past(eng_done);
  endproperty
  a_ccf_rise: assert property (p_ccf_rise) else $error("complete set without engine done"); // R6 R7
  property p_cbef_full;
    @(posedge pclk) disable iff (!presetn) !eng_ready |-> !flags.cbef;
  endproperty
  a_cbef_full: assert property (p_cbef_full) else $error("buffer empty while full"); // R4
  property p_cmd_store;
    @(posedge pclk) disable iff (!presetn) (wr_cmd && seq == fcs_pkg::FCS_SEQ_ADDR) |=> (flash_command == $past(pwdata[6:0]));
  endproperty
  a_cmd_store: assert property (p_cmd_store) else $error("command code not stored"); // R16
endmodule

// *** fcs_defines.svh ***
// Register offsets, field positions, reset values and command codes for the flash command/status block.
// Assumes inclusion by bare name from package and modules.
`ifndef FCS_DEFINES_SVH
`define FCS_DEFINES_SVH
// Register byte offsets
`define FCS_OFF_STATUS 12'h000
`define FCS_OFF_COMMAND 12'h004
`define FCS_OFF_DIVIDER 12'h008
`define FCS_OFF_ARRAY 12'h010
`define FCS_OFF_CTRL 12'h00c
// Status field positions
`define FCS_BIT_CBEF 7
`define FCS_BIT_CCF 6
`define FCS_BIT_PVIOL 5
`define FCS_BIT_ACCERR 4
`define FCS_BIT_BLANK 2
// Divider field
`define FCS_DIV_W 7
`define FCS_DIV_RESET 7'h00
// Command codes
`define FCS_CMD_VERIFY 7'h05
`define FCS_CMD_PROG 7'h20
`define FCS_CMD_BURST 7'h25
`define FCS_CMD_SECTOR 7'h40
`define FCS_CMD_MASS 7'h41
`define FCS_CMD_RESET 7'h00
// Operation length in timing-clock ticks
`define FCS_OP_TICKS 8'h08
`endif

// *** fcs_pkg.sv ***
// Types shared by the flash command/status block.
// Assumes fcs_defines.svh on the include path.
`include "fcs_defines.svh"
package fcs_pkg;
  typedef enum logic [1:0] {
    FCS_SEQ_IDLE,
    FCS_SEQ_ADDR,
    FCS_SEQ_CMD
  } fcs_seq_t;
  // One buffered command
  typedef struct packed {
    logic [6:0] code;
    logic [31:0] addr;
  } fcs_cmd_t;
  // Status flag bundle
  typedef struct packed {
    logic cbef;
    logic ccf;
    logic pviol;
    logic accerr;
    logic blank;
  } fcs_flags_t;
endpackage

// *** fcs_clkdiv.sv ***
// Divider making the flash timing clock enable from the bus clock.
// Assumes divide setting held stable by the register file.
`timescale 1ns/10ps
module fcs_clkdiv #(
  parameter int DIV_W = 7
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic [DIV_W-1:0] div,
  input wire logic prescale8,
  // Timing clock enable
  output logic tick
);
  logic [2:0] pre;
  logic [DIV_W-1:0] cnt;
  logic pre_en;
  // Optional divide by eight ahead of the main counter
  assign pre_en = !prescale8 || (pre == 3'h7);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre <= 3'h0;
    end else begin
      pre <= pre + 3'h1;
    end
  end
  // Divide by div+1, one-cycle pulse per period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (pre_en) begin
        if (cnt >= div) begin
          cnt <= '0;
          tick <= 1'b1;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end
endmodule

// *** fcs_engine.sv ***
// Program/erase engine with a two-stage command store and tick-timed operation.
// Assumes launches only when ready is high; timing ticks from fcs_clkdiv.
`timescale 1ns/10ps
`include "fcs_defines.svh"
module fcs_engine #(
  parameter logic [7:0] OP_TICKS = `FCS_OP_TICKS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Launch side
  input wire logic launch,
  input wire fcs_pkg::fcs_cmd_t cmd,
  output logic ready,
  // Timing and array result
  input wire logic tick,
  input wire logic array_blank,
  // Completion
  output logic busy,
  output logic done,
  output logic verify_done
);
  fcs_pkg::fcs_cmd_t act;
  fcs_pkg::fcs_cmd_t pend;
  logic act_v;
  logic pend_v;
  logic [7:0] cnt;
  logic finish;
  assign finish = act_v && tick && (cnt == OP_TICKS - 8'h01);
  // Pending slot takes any command behind an active command
  assign ready = !pend_v;
  assign busy = act_v || pend_v;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act <= '0;
      pend <= '0;
      act_v <= 1'b0;
      pend_v <= 1'b0;
      cnt <= 8'h00;
      done <= 1'b0;
      verify_done <= 1'b0;
    end else begin
      done <= 1'b0;
      verify_done <= 1'b0;
      if (act_v && tick) begin
        cnt <= cnt + 8'h01;
      end
      if (finish) begin
        cnt <= 8'h00;
        verify_done <= (act.code == `FCS_CMD_VERIFY) && array_blank;
        if (pend_v || launch) begin
          // Next command taken from the pending slot or the same-cycle launch: no completion pulse
          act <= pend_v ? pend : cmd; // R6
          pend_v <= pend_v && launch;
          pend <= cmd;
        end else begin
          act_v <= 1'b0;
          done <= 1'b1;
        end
      end else if (launch) begin
        if (!act_v) begin
          act <= cmd;
          act_v <= 1'b1;
          cnt <= 8'h00;
        end else begin
          pend <= cmd;
          pend_v <= 1'b1;
        end
      end
    end
  end
endmodule

// *** testbench.sv ***
// Self-checking bench for the flash command and status block.
// Assumes fcs_top with a zero-wait APB slave; the bench drives every port itself.
`timescale 1ns/10ps
`include "fcs_defines.svh"
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic addr_protected = 1'b0;
  logic array_blank = 1'b0;
  logic cpu_stop = 1'b0;
  logic flash_busy;
  logic flash_timing_clock;
  int bad_count = 0;
  int checks = 0;
  logic [31:0] rd;

  // Long operation so a second command can be buffered behind the first
  fcs_top #(.OP_TICKS(8'h20)) u_fcs_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .addr_protected(addr_protected), .array_blank(array_blank), .cpu_stop(cpu_stop),
    .flash_busy(flash_busy), .flash_timing_clock(flash_timing_clock)
  );

  // 125 MHz bus clock
  always #4 pclk = ~pclk;

  task automatic summarize();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb_xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      bad_count++;
      $display("BAD t=%0t no ready from slave", $time);
      summarize();
    end
    rd = prdata;
    cmp8({7'h00, pslverr}, 8'h00, "error response");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] addr, input logic [7:0] data);
    apb_xfer(1'b1, addr, {24'h000000, data});
  endtask

  // Masked register read compare
  task automatic rdchk(input logic [11:0] addr, input logic [7:0] mask, input logic [7:0] exp);
    apb_xfer(1'b0, addr, 32'h0000_0000);
    cmp8(rd[7:0] & mask, exp, "register read");
  endtask

  task automatic busy_is(input logic exp);
    @(negedge pclk);
    cmp8({7'h00, flash_busy}, {7'h00, exp}, "busy output");
  endtask

  // Address, code, then launch with no other writes between
  task automatic seq(input logic [7:0] code);
    wr(`FCS_OFF_ARRAY, 8'h40);
    wr(`FCS_OFF_COMMAND, code);
    wr(`FCS_OFF_STATUS, 8'h80);
  endtask

  // Program the divider, skip one edge, then count ticks in a window
  task automatic ticks_are(input logic [7:0] setting, input int win, input logic [7:0] exp);
    int cnt;
    wr(`FCS_OFF_DIVIDER, setting);
    @(posedge pclk);
    cnt = 0;
    repeat (win) begin
      @(negedge pclk);
      if (flash_timing_clock === 1'b1) cnt++;
    end
    cmp8(cnt[7:0], exp, "timing ticks");
  endtask

  // Poll until the buffer frees; complete must still be low then
  task automatic poll_cbef();
    int n;
    n = 0;
    do begin
      apb_xfer(1'b0, `FCS_OFF_STATUS, 32'h0000_0000);
      n++;
    end while (rd[`FCS_BIT_CBEF] !== 1'b1 && n < 100);
    cmp8(rd[7:0] & 8'hc0, 8'h80, "buffer free while busy");
    if (rd[`FCS_BIT_CBEF] !== 1'b1) begin
      summarize();
    end
  endtask

  // Poll status until complete; engine must be idle by then
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb_xfer(1'b0, `FCS_OFF_STATUS, 32'h0000_0000);
      n++;
    end while (rd[`FCS_BIT_CCF] !== 1'b1 && n < 200);
    if (rd[`FCS_BIT_CCF] !== 1'b1) begin
      bad_count++;
      $display("BAD t=%0t complete flag never set", $time);
      summarize();
    end
    busy_is(1'b0);
  endtask

  task automatic t_reset();
    rdchk(`FCS_OFF_STATUS, 8'hff, 8'hc0);
    rdchk(`FCS_OFF_COMMAND, 8'hff, 8'h00);
    rdchk(12'h020, 8'hff, 8'h00);
    rdchk(`FCS_OFF_CTRL, 8'hff, 8'h00);
    wr(`FCS_OFF_STATUS, 8'h4f);
    rdchk(`FCS_OFF_STATUS, 8'hff, 8'hc0);
  endtask

  task automatic t_nodiv();
    seq(`FCS_CMD_PROG);
    rdchk(`FCS_OFF_STATUS, 8'h30, 8'h10);
    busy_is(1'b0);
    wr(`FCS_OFF_STATUS, 8'h00);
    rdchk(`FCS_OFF_STATUS, 8'h30, 8'h10);
    wr(`FCS_OFF_STATUS, 8'h10);
    rdchk(`FCS_OFF_STATUS, 8'hff, 8'hc0);
  endtask

  // Divide by four, by eight with the prescaler, then by one for fast runs
  task automatic t_divider();
    ticks_are(8'h03, 20, 8'h05);
    ticks_are(8'h80, 24, 8'h03);
    ticks_are(8'h00, 20, 8'h14);
    rdchk(`FCS_OFF_DIVIDER, 8'hff, 8'h00);
    rdchk(`FCS_OFF_CTRL, 8'h03, 8'h02);
  endtask

  // Every valid code runs; verify reports the array state
  task automatic t_codes();
    logic [7:0] codes [6];
    codes = '{`FCS_CMD_VERIFY, `FCS_CMD_PROG, `FCS_CMD_BURST, `FCS_CMD_SECTOR, `FCS_CMD_MASS, `FCS_CMD_VERIFY};
    for (int i = 0; i < 6; i++) begin
      array_blank <= (i == 0);
      seq(codes[i]);
      rdchk(`FCS_OFF_STATUS, 8'h74, 8'h00);
      busy_is(1'b1);
      wait_done();
      rdchk(`FCS_OFF_STATUS, 8'hff, (i == 0) ? 8'hc4 : 8'hc0);
    end
  endtask

  task automatic t_ccf_write();
    seq(`FCS_CMD_SECTOR);
    wr(`FCS_OFF_STATUS, 8'h40);
    rdchk(`FCS_OFF_STATUS, 8'h50, 8'h00);
    wait_done();
  endtask

  task automatic t_abort();
    wr(`FCS_OFF_ARRAY, 8'h40);
    wr(`FCS_OFF_STATUS, 8'h00);
    rdchk(`FCS_OFF_STATUS, 8'hff, 8'hd0);
    seq(`FCS_CMD_PROG);
    rdchk(`FCS_OFF_STATUS, 8'h50, 8'h50);
    busy_is(1'b0);
    wr(`FCS_OFF_STATUS, 8'h10);
    wr(`FCS_OFF_ARRAY, 8'h40);
    wr(`FCS_OFF_COMMAND, 8'h7f);
    rdchk(`FCS_OFF_STATUS, 8'h10, 8'h10);
    wr(`FCS_OFF_STATUS, 8'h10);
    wr(`FCS_OFF_ARRAY, 8'h40);
    wr(`FCS_OFF_ARRAY, 8'h40);
    rdchk(`FCS_OFF_STATUS, 8'h10, 8'h10);
    wr(`FCS_OFF_STATUS, 8'h10);
  endtask

  task automatic t_cmd_reg();
    wr(`FCS_OFF_ARRAY, 8'h40);
    wr(`FCS_OFF_COMMAND, 8'ha0);
    rdchk(`FCS_OFF_COMMAND, 8'hff, 8'h20);
    wr(`FCS_OFF_STATUS, 8'h80);
    wait_done();
    rdchk(`FCS_OFF_STATUS, 8'hff, 8'hc0);
  endtask

  task automatic t_protect();
    addr_protected <= 1'b1;
    wr(`FCS_OFF_ARRAY, 8'h40);
    addr_protected <= 1'b0;
    rdchk(`FCS_OFF_STATUS, 8'h20, 8'h20);
    wr(`FCS_OFF_STATUS, 8'h00);
    seq(`FCS_CMD_PROG);
    rdchk(`FCS_OFF_STATUS, 8'h60, 8'h60);
    busy_is(1'b0);
    wr(`FCS_OFF_STATUS, 8'h30);
    rdchk(`FCS_OFF_STATUS, 8'hff, 8'hc0);
  endtask

  // Stop while running flags an error; stop while idle does not
  task automatic t_stop();
    seq(`FCS_CMD_PROG);
    cpu_stop <= 1'b1;
    @(posedge pclk);
    cpu_stop <= 1'b0;
    wait_done();
    rdchk(`FCS_OFF_STATUS, 8'hff, 8'hd0);
    wr(`FCS_OFF_STATUS, 8'h10);
    cpu_stop <= 1'b1;
    @(posedge pclk);
    cpu_stop <= 1'b0;
    rdchk(`FCS_OFF_STATUS, 8'hff, 8'hc0);
  endtask

  // Burst queued behind a program keeps complete low until both end
  task automatic t_burst();
    seq(`FCS_CMD_PROG);
    poll_cbef();
    seq(`FCS_CMD_BURST);
    rdchk(`FCS_OFF_STATUS, 8'hc0, 8'h00);
    poll_cbef();
    busy_is(1'b1);
    wait_done();
    rdchk(`FCS_OFF_STATUS, 8'hff, 8'hc0);
  endtask

  // Watchdog against a hang anywhere
  initial begin
    #800000;
    bad_count++;
    $display("BAD t=%0t run limit reached", $time);
    summarize();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_nodiv();
    t_divider();
    t_codes();
    t_ccf_write();
    t_abort();
    t_cmd_reg();
    t_protect();
    t_stop();
    t_burst();
    summarize();
  end
endmodule
